//--- pmc_pkg.sv
// Purpose: shared constants and types of the power mode controller
// Assumes: 32-bit register port, word-aligned byte offsets
// Notes:   offsets are byte addresses, one register per word
package pmc_pkg;

  // --------------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------------
  localparam logic [7:0] PMC_OFS_PLL_CTRL   = 8'h00; // pll_control_reg
  localparam logic [7:0] PMC_OFS_MODE_CMD   = 8'h04; // mode request strobes
  localparam logic [7:0] PMC_OFS_REG_CTRL   = 8'h08; // regulator_control_reg
  localparam logic [7:0] PMC_OFS_WAKE_EN    = 8'h0C; // wakeup_enable_regs
  localparam logic [7:0] PMC_OFS_STATUS     = 8'h10; // mode and pin status
  localparam logic [7:0] PMC_OFS_CLK_GATE   = 8'h14; // peripheral clock gates

  // --------------------------------------------------------------------
  // field positions and widths
  // --------------------------------------------------------------------
  localparam int PMC_PLL_BYPASS_BIT  = 0;
  localparam int PMC_PLL_OFF_BIT     = 1;
  localparam int PMC_CMD_SLEEP_BIT   = 0;
  localparam int PMC_CMD_DEEP_BIT    = 1;
  localparam int PMC_REG_HIB_N_BIT   = 0;  // 0 requests hibernate
  localparam int PMC_REG_WEN_LSB     = 1;  // hibernate wake enables
  localparam int PMC_HIB_SRC_W       = 4;
  localparam int PMC_WAKE_SRC_W      = 8;
  localparam int PMC_PERIPH_W        = 16;
  localparam int PMC_STAT_PG_BIT     = 6;
  localparam int PMC_STAT_WAKE_BIT   = 7;

  // --------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------
  localparam logic       PMC_RST_BYPASS   = 1'b0;
  localparam logic       PMC_RST_PLL_OFF  = 1'b0;
  localparam logic       PMC_RST_HIB_N    = 1'b1;
  localparam logic [3:0] PMC_RST_HIB_WEN  = 4'h0;
  localparam logic [7:0] PMC_RST_WAKE_EN  = 8'h00;
  localparam logic [15:0] PMC_RST_GATE    = 16'hFFFF;

  // --------------------------------------------------------------------
  // operating states, one-hot
  // --------------------------------------------------------------------
  typedef enum logic [5:0] {
    PMC_ST_RST_SEQ = 6'h01,
    PMC_ST_FULL_ON = 6'h02,
    PMC_ST_ACTIVE  = 6'h04,
    PMC_ST_SLEEP   = 6'h08,
    PMC_ST_DEEP    = 6'h10,
    PMC_ST_HIB     = 6'h20
  } pmc_state_t;

endpackage

//--- pmc_clk_gate.sv
// Purpose: per-peripheral clock enable gating
// Assumes: enables are registered, one cycle behind their inputs
// Notes:   a gated peripheral stays off whatever the mode
`timescale 1ns/1ps
module pmc_clk_gate #(
  parameter int N = 16
) (
  input  wire logic         i_clock,
  input  wire logic         i_rst,
  input  wire logic         i_sys_en,
  input  wire logic [N-1:0] i_mask,
  output logic      [N-1:0] o_en
);

  // --------------------------------------------------------------------
  // one flop per peripheral
  // --------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gate
      // system clock must run and the peripheral be ungated
      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          o_en[g] <= 1'b0;
        end else begin
          o_en[g] <= i_sys_en & i_mask[g];
        end
      end
    end
  endgenerate

endmodule

//--- pmc_power_mode_ctrl.sv
// Purpose: power mode controller: six states, clock and pll control,
//          sleep wakeup, reset recovery and regulator signalling
// Assumes: i_rst is the io-supply power-on reset; the reset pin is a
//          synchronous active-low input
// Notes:   all outputs are registered, one cycle behind the state
`timescale 1ns/1ps

module pmc_power_mode_ctrl (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_reset_pin_n,
  input  wire logic        i_power_good_in_n,
  input  wire logic [7:0]  i_wake_src,
  input  wire logic [3:0]  i_hib_wake_src,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  output logic             o_core_clk_en,
  output logic             o_sys_clk_en,
  output logic             o_pll_en,
  output logic             o_pll_bypass,
  output logic             o_dma_l1_allow,
  output logic             o_async_access_allow,
  output logic             o_pins_hiz,
  output logic             o_regulator_wake_out,
  output logic [5:0]       o_mode,
  output logic [15:0]      o_periph_clk_en
);

  // --------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------
  pmc_pkg::pmc_state_t state;
  pmc_pkg::pmc_state_t next_state;
  logic        pll_bypass;
  logic        pll_off;
  logic        hib_n;
  logic [3:0]  hib_wen;
  logic [7:0]  wake_en;
  logic [15:0] gate_mask;
  logic        wake_hit;
  logic        hib_wake;
  logic        seq_clear;
  logic        running;
  logic        wr_pll;
  logic        wr_cmd;
  logic        wr_reg;
  logic        wr_wen;
  logic        wr_gate;
  logic        sys_en_next;

  // address match, used by every write decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  assign wr_pll  = i_wr & hit(i_addr, pmc_pkg::PMC_OFS_PLL_CTRL);
  assign wr_cmd  = i_wr & hit(i_addr, pmc_pkg::PMC_OFS_MODE_CMD);
  assign wr_reg  = i_wr & hit(i_addr, pmc_pkg::PMC_OFS_REG_CTRL);
  assign wr_wen  = i_wr & hit(i_addr, pmc_pkg::PMC_OFS_WAKE_EN);
  assign wr_gate = i_wr & hit(i_addr, pmc_pkg::PMC_OFS_CLK_GATE);

  assign running  = (state == pmc_pkg::PMC_ST_FULL_ON) |
                    (state == pmc_pkg::PMC_ST_ACTIVE);
  assign wake_hit = |(i_wake_src & wake_en);
  assign hib_wake = |(i_hib_wake_src & hib_wen);
  // reset sequence wipes everything but the regulator register
  assign seq_clear = (state == pmc_pkg::PMC_ST_RST_SEQ);

  // --------------------------------------------------------------------
  // mode state machine
  // --------------------------------------------------------------------
  // reset pin beats any other transition, in every state
  always_comb begin
    next_state = state;
    case (state)
      pmc_pkg::PMC_ST_RST_SEQ: begin
        // core held until the supply is good
        if (!i_power_good_in_n) begin
          next_state = pmc_pkg::PMC_ST_FULL_ON;
        end
      end
      pmc_pkg::PMC_ST_FULL_ON, pmc_pkg::PMC_ST_ACTIVE: begin
        if (wr_reg && !i_wdata[pmc_pkg::PMC_REG_HIB_N_BIT]) begin
          next_state = pmc_pkg::PMC_ST_HIB;
        end else if (wr_cmd && i_wdata[pmc_pkg::PMC_CMD_DEEP_BIT]) begin
          next_state = pmc_pkg::PMC_ST_DEEP;
        end else if (wr_cmd && i_wdata[pmc_pkg::PMC_CMD_SLEEP_BIT] &&
                     !pll_off) begin
          // sleep needs a live pll; a request with it off is dropped
          next_state = pmc_pkg::PMC_ST_SLEEP;
        end else if (pll_bypass) begin
          next_state = pmc_pkg::PMC_ST_ACTIVE;
        end else if (!pll_off) begin
          next_state = pmc_pkg::PMC_ST_FULL_ON;
        end
      end
      pmc_pkg::PMC_ST_SLEEP: begin
        if (wake_hit) begin
          next_state = pll_bypass ? pmc_pkg::PMC_ST_ACTIVE
                                  : pmc_pkg::PMC_ST_FULL_ON;
        end
      end
      pmc_pkg::PMC_ST_DEEP: begin
        next_state = state; // only the reset pin leaves
      end
      pmc_pkg::PMC_ST_HIB: begin
        if (hib_wake) begin
          next_state = pmc_pkg::PMC_ST_RST_SEQ;
        end
      end
      default: begin
        next_state = pmc_pkg::PMC_ST_RST_SEQ;
      end
    endcase
    if (!i_reset_pin_n) begin
      next_state = pmc_pkg::PMC_ST_RST_SEQ;
    end
  end

  // state register
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state <= pmc_pkg::PMC_ST_RST_SEQ;
    end else begin
      state <= next_state;
    end
  end

  // --------------------------------------------------------------------
  // registers lost in hibernate
  // --------------------------------------------------------------------
  // pll control: cleared by every hardware reset sequence
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pll_bypass <= pmc_pkg::PMC_RST_BYPASS;
      pll_off    <= pmc_pkg::PMC_RST_PLL_OFF;
    end else if (seq_clear) begin
      pll_bypass <= pmc_pkg::PMC_RST_BYPASS;
      pll_off    <= pmc_pkg::PMC_RST_PLL_OFF;
    end else if (wr_pll) begin
      pll_bypass <= i_wdata[pmc_pkg::PMC_PLL_BYPASS_BIT];
      pll_off    <= i_wdata[pmc_pkg::PMC_PLL_OFF_BIT];
    end
  end

  // sleep wakeup enables and clock gates
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wake_en   <= pmc_pkg::PMC_RST_WAKE_EN;
      gate_mask <= pmc_pkg::PMC_RST_GATE;
    end else if (seq_clear) begin
      wake_en   <= pmc_pkg::PMC_RST_WAKE_EN;
      gate_mask <= pmc_pkg::PMC_RST_GATE;
    end else begin
      if (wr_wen) begin
        wake_en <= i_wdata[7:0];
      end
      if (wr_gate) begin
        gate_mask <= i_wdata[15:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // regulator control, kept while the io supply stays
  // --------------------------------------------------------------------
  // only i_rst (io power-on) clears it; a wake event sets the
  // power-up bit again and wins over a write in the same cycle
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      hib_n   <= pmc_pkg::PMC_RST_HIB_N;
      hib_wen <= pmc_pkg::PMC_RST_HIB_WEN;
    end else begin
      if (wr_reg) begin
        hib_wen <= i_wdata[4:1];
      end
      if (state == pmc_pkg::PMC_ST_HIB &&
          (hib_wake || !i_reset_pin_n)) begin
        hib_n <= 1'b1;
      end else if (wr_reg && running) begin
        hib_n <= i_wdata[pmc_pkg::PMC_REG_HIB_N_BIT];
      end
    end
  end

  // --------------------------------------------------------------------
  // registered control outputs
  // --------------------------------------------------------------------
  assign sys_en_next = running | (state == pmc_pkg::PMC_ST_SLEEP);

  // clock, pll and access enables follow the state
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_core_clk_en        <= 1'b0;
      o_sys_clk_en         <= 1'b0;
      o_pll_en             <= 1'b0;
      o_pll_bypass         <= 1'b0;
      o_dma_l1_allow       <= 1'b0;
      o_async_access_allow <= 1'b0;
      o_pins_hiz           <= 1'b0;
    end else begin
      o_core_clk_en  <= running;
      o_sys_clk_en   <= sys_en_next;
      // pll_off shuts the pll only in active; sleep keeps it alive, deep and hibernate stop it
      o_pll_en       <= sys_en_next &
                        !((state == pmc_pkg::PMC_ST_ACTIVE) & pll_off);
      o_pll_bypass   <= (state == pmc_pkg::PMC_ST_ACTIVE);
      o_dma_l1_allow <= running;
      o_async_access_allow <= running |
                              (state == pmc_pkg::PMC_ST_SLEEP);
      o_pins_hiz     <= (state == pmc_pkg::PMC_ST_HIB);
    end
  end

  // high wake output asks the regulator for core power
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_regulator_wake_out <= pmc_pkg::PMC_RST_HIB_N;
      o_mode               <= pmc_pkg::PMC_ST_RST_SEQ;
    end else begin
      o_regulator_wake_out <= hib_n;
      o_mode               <= state;
    end
  end

  // --------------------------------------------------------------------
  // register read port, data one cycle after the strobe
  // --------------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      case (i_addr)
        pmc_pkg::PMC_OFS_PLL_CTRL: o_rdata <= {30'h0, pll_off, pll_bypass};
        pmc_pkg::PMC_OFS_REG_CTRL: o_rdata <= {27'h0, hib_wen, hib_n};
        pmc_pkg::PMC_OFS_WAKE_EN:  o_rdata <= {24'h0, wake_en};
        pmc_pkg::PMC_OFS_CLK_GATE: o_rdata <= {16'h0, gate_mask};
        pmc_pkg::PMC_OFS_STATUS: begin
          o_rdata <= {24'h0, hib_n, !i_power_good_in_n, state};
        end
        default: o_rdata <= 32'h0000_0000; // command and unmapped read 0
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------
  // peripheral clock gating
  // --------------------------------------------------------------------
  pmc_clk_gate #(
    .N (pmc_pkg::PMC_PERIPH_W)
  ) u_gate (
    .i_clock  (i_clock),
    .i_rst    (i_rst),
    .i_sys_en (sys_en_next),
    .i_mask   (gate_mask),
    .o_en     (o_periph_clk_en)
  );

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  sequence s_in_sleep;
    state == pmc_pkg::PMC_ST_SLEEP;
  endsequence

  sequence s_hib_req;
    running && wr_reg && !i_wdata[pmc_pkg::PMC_REG_HIB_N_BIT] &&
    i_reset_pin_n;
  endsequence

  a_pin_reset_seq: assert property (!i_reset_pin_n |=>
    state == pmc_pkg::PMC_ST_RST_SEQ)
    else $error("reset pin did not start the reset sequence");

  a_sleep_wake_full: assert property (s_in_sleep ##0 (wake_hit &&
    !pll_bypass && i_reset_pin_n) |=> state == pmc_pkg::PMC_ST_FULL_ON)
    else $error("sleep wake with bypass clear missed full-on");

  a_sleep_wake_act: assert property (s_in_sleep ##0 (wake_hit &&
    pll_bypass && i_reset_pin_n) |=> state == pmc_pkg::PMC_ST_ACTIVE)
    else $error("sleep wake with bypass set missed active");

  a_hib_entry_out: assert property (s_hib_req |=>
    state == pmc_pkg::PMC_ST_HIB ##1 !o_regulator_wake_out && o_pins_hiz)
    else $error("hibernate write did not drop wake output");

  a_sleep_clocks: assert property (s_in_sleep |=>
    !o_core_clk_en && o_sys_clk_en && o_pll_en && !o_dma_l1_allow)
    else $error("sleep clock or dma enables wrong");

  a_deep_clocks: assert property (state == pmc_pkg::PMC_ST_DEEP |=>
    !o_core_clk_en && !o_sys_clk_en && !o_async_access_allow)
    else $error("deep sleep left a clock or access open");

  a_active_bypass: assert property (
    state == pmc_pkg::PMC_ST_ACTIVE |=>
    o_pll_bypass && o_core_clk_en && o_dma_l1_allow)
    else $error("active mode without bypass or dma");

  a_pg_hold_off: assert property (
    (state == pmc_pkg::PMC_ST_RST_SEQ && i_power_good_in_n) |=>
    !running ##1 !o_core_clk_en)
    else $error("core started before power good");

  a_hib_wake_rpt: assert property (
    (state == pmc_pkg::PMC_ST_HIB && hib_wake) |=>
    state == pmc_pkg::PMC_ST_RST_SEQ ##1 o_regulator_wake_out)
    else $error("hibernate wake not reported to regulator");

  a_reg_kept: assert property ((seq_clear && !wr_reg) |=>
    $stable(hib_wen) && pll_bypass == pmc_pkg::PMC_RST_BYPASS &&
    wake_en == pmc_pkg::PMC_RST_WAKE_EN)
    else $error("reset sequence cleared wrong registers");

endmodule

//--- pmc_regulator_model.sv
// Purpose: behavioural external core regulator for the mode controller
// Assumes: wake high asks for core power, power good is active low
// Notes:   ramp length is selectable, prompt or slow
`timescale 1ns/1ps
module pmc_regulator_model (
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_wake,
  input  wire logic i_slow,
  output logic      o_power_good_n
);
  // ------------------------------------------------------------
  // supply ramp
  // ------------------------------------------------------------
  logic [5:0] ramp;

  // supply collapses on the first clock with wake low, so good lingers at most one cycle
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ramp <= 6'h00;
    end else if (!i_wake) begin
      ramp <= 6'h00;
    end else if (ramp != 6'h3F) begin
      ramp <= ramp + 6'h01;
    end
  end

  // good only once the ramp passes the selected length
  assign o_power_good_n = i_slow ? (ramp < 6'h14) : (ramp < 6'h02);
endmodule

//--- pmc_power_mode_ctrl_test.sv
// Purpose: self-checking bench of the power mode controller
// Assumes: regulator model closes the power good loop
// Notes:   each scenario is a task that judges its own results
`timescale 1ns/1ps
module pmc_power_mode_ctrl_test;
  // ------------------------------------------------------------
  // stimulus, model and design
  // ------------------------------------------------------------
  logic        i_clock = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_reset_pin_n = 1'b1;
  logic        slow = 1'b1;
  logic        pg_n;
  logic [7:0]  i_wake_src = 8'h00;
  logic [3:0]  i_hib_wake_src = 4'h0;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic        core, sys, pll, byp, dma, asy, hiz, wake;
  logic [5:0]  o_mode;
  logic [15:0] o_periph_clk_en;
  logic [31:0] rdv;
  int          failures = 0;
  int          cmp_count = 0;
  wire  [7:0]  outs = {core, sys, pll, byp, dma, asy, hiz, wake};

`define CHK(g, w) begin cmp_count++; if ((g) !== (w)) begin failures++; \
  $display("unexpected at %0t: got %h want %h", $time, g, w); end end

  always #2 i_clock = ~i_clock;

  pmc_regulator_model reg_u (
    .i_clock        (i_clock),
    .i_rst          (i_rst),
    .i_wake         (wake),
    .i_slow         (slow),
    .o_power_good_n (pg_n)
  );

  pmc_power_mode_ctrl dut_u (
    .i_clock              (i_clock),
    .i_rst                (i_rst),
    .i_reset_pin_n        (i_reset_pin_n),
    .i_power_good_in_n    (pg_n),
    .i_wake_src           (i_wake_src),
    .i_hib_wake_src       (i_hib_wake_src),
    .i_addr               (i_addr),
    .i_wdata              (i_wdata),
    .i_wr                 (i_wr),
    .i_rd                 (i_rd),
    .o_rdata              (o_rdata),
    .o_core_clk_en        (core),
    .o_sys_clk_en         (sys),
    .o_pll_en             (pll),
    .o_pll_bypass         (byp),
    .o_dma_l1_allow       (dma),
    .o_async_access_allow (asy),
    .o_pins_hiz           (hiz),
    .o_regulator_wake_out (wake),
    .o_mode               (o_mode),
    .o_periph_clk_en      (o_periph_clk_en)
  );

  // ------------------------------------------------------------
  // bus and wait helpers
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  // bounded wait, so a stuck state machine shows as a mismatch
  task automatic wait_mode(input pmc_pkg::pmc_state_t m, input int n);
    for (int i = 0; i < n && o_mode !== m; i++) cyc(1);
    `CHK(o_mode, m)
  endtask

  task automatic pin_reset();
    @(posedge i_clock);
    i_reset_pin_n <= 1'b0;
    cyc(3);
    `CHK(o_mode, pmc_pkg::PMC_ST_RST_SEQ)
    @(posedge i_clock);
    i_reset_pin_n <= 1'b1;
    wait_mode(pmc_pkg::PMC_ST_FULL_ON, 40);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_power_up();
    cyc(4);
    `CHK(o_mode, pmc_pkg::PMC_ST_RST_SEQ)
    wait_mode(pmc_pkg::PMC_ST_FULL_ON, 40);
    cyc(2);
    `CHK(outs, 8'hED)
    rd(8'h00, rdv);
    `CHK(rdv, 32'h0000_0000)
    rd(8'h08, rdv);
    `CHK(rdv, 32'h0000_0001)
    rd(8'h14, rdv);
    `CHK(rdv, 32'h0000_FFFF)
    rd(8'h18, rdv);
    `CHK(rdv, 32'h0000_0000)
    // status: wake output bit, power good bit and the full-on code
    rd(8'h10, rdv);
    `CHK(rdv, 32'h0000_00C2)
    `CHK(o_periph_clk_en, 16'hFFFF)
  endtask

  task automatic t_active_gate();
    wr(8'h14, 32'h0000_00A5);
    cyc(3);
    `CHK(o_periph_clk_en, 16'h00A5)
    wr(8'h00, 32'h0000_0001);
    cyc(3);
    `CHK(o_mode, pmc_pkg::PMC_ST_ACTIVE)
    `CHK(outs, 8'hFD)
    rd(8'h10, rdv);
    `CHK(rdv[5:0], 6'h04)
    wr(8'h00, 32'h0000_0003);
    cyc(3);
    `CHK(outs, 8'hDD)
    // a sleep request with the pll input off must be ignored
    wr(8'h04, 32'h0000_0001);
    cyc(3);
    `CHK(o_mode, pmc_pkg::PMC_ST_ACTIVE)
  endtask

  task automatic sleep_wake(input logic b);
    wr(8'h00, {31'h0, b});
    wr(8'h0C, 32'h0000_0004);
    wr(8'h04, 32'h0000_0001);
    cyc(3);
    `CHK(o_mode, pmc_pkg::PMC_ST_SLEEP)
    `CHK(outs, 8'h65)
    @(posedge i_clock);
    i_wake_src <= 8'h08;
    cyc(5);
    `CHK(o_mode, pmc_pkg::PMC_ST_SLEEP)
    @(posedge i_clock);
    i_wake_src <= 8'h0C;
    wait_mode(b ? pmc_pkg::PMC_ST_ACTIVE : pmc_pkg::PMC_ST_FULL_ON,
              5);
    @(posedge i_clock);
    i_wake_src <= 8'h00;
    cyc(2);
    `CHK(byp, b)
  endtask

  task automatic t_deep();
    wr(8'h04, 32'h0000_0002);
    cyc(3);
    `CHK(o_mode, pmc_pkg::PMC_ST_DEEP)
    `CHK(outs, 8'h01)
    `CHK(o_periph_clk_en, 16'h0000)
    @(posedge i_clock);
    i_wake_src <= 8'hFF;
    cyc(6);
    `CHK(o_mode, pmc_pkg::PMC_ST_DEEP)
    @(posedge i_clock);
    i_wake_src <= 8'h00;
    pin_reset();
    rd(8'h14, rdv);
    `CHK(rdv, 32'h0000_FFFF)
  endtask

  task automatic t_hibernate();
    wr(8'h14, 32'h0000_00A5);
    wr(8'h0C, 32'h0000_0004);
    wr(8'h08, 32'h0000_0004);
    cyc(3);
    `CHK(o_mode, pmc_pkg::PMC_ST_HIB)
    `CHK(outs, 8'h02)
    // supply gone: power good and wake bits low, hibernate code shown
    rd(8'h10, rdv);
    `CHK(rdv, 32'h0000_0020)
    @(posedge i_clock);
    i_hib_wake_src <= 4'h1;
    cyc(6);
    `CHK(o_mode, pmc_pkg::PMC_ST_HIB)
    @(posedge i_clock);
    i_hib_wake_src <= 4'h2;
    wait_mode(pmc_pkg::PMC_ST_RST_SEQ, 5);
    @(posedge i_clock);
    i_hib_wake_src <= 4'h0;
    cyc(2);
    `CHK(wake, 1'b1)
    `CHK(o_mode, pmc_pkg::PMC_ST_RST_SEQ)
    wait_mode(pmc_pkg::PMC_ST_FULL_ON, 40);
    rd(8'h08, rdv);
    `CHK(rdv, 32'h0000_0005)
    rd(8'h0C, rdv);
    `CHK(rdv, 32'h0000_0000)
    rd(8'h14, rdv);
    `CHK(rdv, 32'h0000_FFFF)
    wr(8'h08, 32'h0000_0000);
    cyc(3);
    `CHK(o_mode, pmc_pkg::PMC_ST_HIB)
    pin_reset();
    `CHK(wake, 1'b1)
  endtask

  // ------------------------------------------------------------
  // verdict and sequence
  // ------------------------------------------------------------
  task automatic final_report();
    if (failures == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // the whole run needs well under a thousand cycles
  initial begin
    #40000;
    failures++;
    final_report();
  end

  initial begin
    repeat (12) @(posedge i_clock);
    i_rst <= 1'b0;
    t_power_up();
    slow <= 1'b0;
    t_active_gate();
    sleep_wake(1'b1);
    sleep_wake(1'b0);
    t_deep();
    slow <= 1'b1;
    t_hibernate();
    final_report();
  end
endmodule
